/* e3tx_top.sv */
// E3 transmit overhead generation, alarm forcing and framing error insertion
//
// Implementation choice: the AXI4-Lite slave port.
`include "e3tx_regs.svh"

module e3tx_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic in_bit,
	input wire logic in_valid,
	input wire logic in_frame_start,
	input wire logic hdlc_bit,
	input wire logic feac_bit,
	input wire logic rx_los,
	input wire logic manual_error_input,
	output logic tx_bit_r,
	output logic tx_valid_r,
	output logic tx_frame_start_r
);
	e3tx_pkg::e3tx_state_t s_r;
	e3tx_pkg::e3tx_state_t s_nxt;
	e3tx_pkg::e3tx_nsrc_t n_bit_source_select;
	e3tx_pkg::e3tx_asrc_t a_bit_source_select;
	logic [1:0] framing_error_type;
	logic frame_generation_disable;
	logic force_all_ones_alarm;
	logic framing_error_inject_enable;
	logic software_single_error;
	logic insert_trigger_select;
	logic trig_level;
	logic trig_edge;
	logic [10:0] pos;
	logic take;
	logic frame_err_now;
	logic apply;
	logic a_val;
	logic n_val;
	logic gen_bit;
	logic [9:0] fas_word;

	// Field views of the two control registers
	assign n_bit_source_select = e3tx_pkg::e3tx_nsrc_t'(
		s_r.ctrl[`E3TX_N_SRC_LSB +: 2]);
	assign a_bit_source_select = e3tx_pkg::e3tx_asrc_t'(
		s_r.ctrl[`E3TX_A_SRC_LSB +: 2]);
	assign frame_generation_disable = s_r.ctrl[`E3TX_FGD_BIT];
	assign force_all_ones_alarm = s_r.ctrl[`E3TX_AIS_BIT];
	assign framing_error_type = s_r.eins[`E3TX_ETYPE_LSB +: 2];
	assign framing_error_inject_enable = s_r.eins[`E3TX_FEI_BIT];
	assign software_single_error = s_r.eins[`E3TX_SWERR_BIT];
	assign insert_trigger_select = s_r.eins[`E3TX_TRIGSEL_BIT];

	// Edge of the selected trigger; toggling the select while a source is
	// high produces an edge too, which is why software keeps them low then
	assign trig_level = insert_trigger_select ? manual_error_input
		: software_single_error;
	assign trig_edge = trig_level & ~s_r.trig_prev;

	// Bit position in the frame; a frame start mark realigns the count
	assign pos = in_frame_start ? 11'h000 : s_r.pos;
	assign take = in_valid && (pos == 11'h000);
	assign frame_err_now = take ? (s_r.pending || (s_r.frames_left != 2'h0))
		: s_r.frame_err;
	// Single error hits the first alignment bit, word error all ten
	assign apply = in_valid && framing_error_inject_enable && frame_err_now
		&& ((pos == 11'h000) || ((take ? framing_error_type[0]
		: s_r.err_word) && (pos < `E3TX_FAS_LEN)));

	// Overhead sources; the two FEAC taps sample the controller at their
	// own bit times, so N and A may differ in one frame
	always_comb
	begin
		a_val = 1'b0;
		n_val = 1'b1;
		unique case (a_bit_source_select)
			e3tx_pkg::E3TX_A_AUTO: a_val = rx_los & ~s_r.rai_los_dis;
			e3tx_pkg::E3TX_A_FEAC: a_val = feac_bit;
			e3tx_pkg::E3TX_A_ZERO: a_val = 1'b0;
			e3tx_pkg::E3TX_A_ONE: a_val = 1'b1;
		endcase
		unique case (n_bit_source_select)
			e3tx_pkg::E3TX_N_ONE: n_val = 1'b1;
			e3tx_pkg::E3TX_N_HDLC: n_val = hdlc_bit;
			e3tx_pkg::E3TX_N_FEAC: n_val = feac_bit;
			e3tx_pkg::E3TX_N_ZERO: n_val = 1'b0;
		endcase
	end

	// Alignment word as a vector, so each bit time picks exactly one bit
	assign fas_word = `E3TX_FAS_PATTERN;

	// Generated overhead, or the incoming bit when generation is off
	always_comb
	begin
		gen_bit = in_bit;
		if (!frame_generation_disable)
		begin
			if (pos < `E3TX_FAS_LEN)
				gen_bit = fas_word[4'h9 - pos[3:0]];
			else if (pos == `E3TX_A_POS)
				gen_bit = a_val;
			else if (pos == `E3TX_N_POS)
				gen_bit = n_val;
		end
	end

	// Whole next state: bus slave, registers, insertion control, stream
	always_comb
	begin
		s_nxt = s_r;
		// Write address and data may arrive in either order
		if (s_r.awready && s_axi_awvalid)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_r.wready && s_axi_wvalid)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
		begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `E3TX_RESP_OKAY;
			unique case (s_r.aw_addr)
				{`E3TX_IDX_CONTROL, 2'b00}:
				begin
					if (s_r.w_strb[0])
						s_nxt.ctrl[7:0] = s_r.w_data[7:0];
					if (s_r.w_strb[1])
						s_nxt.ctrl[15:8] = s_r.w_data[15:8];
					// Reserved positions never hold a one
					s_nxt.ctrl = s_nxt.ctrl
						& `E3TX_CONTROL_MASK;
				end
				{`E3TX_IDX_ERR_INS, 2'b00}:
				begin
					if (s_r.w_strb[0])
						s_nxt.eins[7:0] = s_r.w_data[7:0];
					s_nxt.eins = s_nxt.eins
						& `E3TX_ERR_INS_MASK;
				end
				{`E3TX_IDX_RAI_CTRL, 2'b00}:
				begin
					if (s_r.w_strb[0])
						s_nxt.rai_los_dis = s_r.w_data[`E3TX_RAI_LOS_DIS_BIT];
				end
				{`E3TX_IDX_STATUS, 2'b00}: s_nxt.bresp = `E3TX_RESP_OKAY;
				default: s_nxt.bresp = `E3TX_RESP_SLVERR;
			endcase
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		// One read at a time; answer one cycle after the address is taken
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		if (s_r.arready && s_axi_arvalid)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `E3TX_RESP_OKAY;
			s_nxt.rdata = 32'h00000000;
			unique case (s_axi_araddr)
				{`E3TX_IDX_CONTROL, 2'b00}: s_nxt.rdata[15:0] = s_r.ctrl;
				{`E3TX_IDX_ERR_INS, 2'b00}: s_nxt.rdata[15:0] = s_r.eins;
				{`E3TX_IDX_RAI_CTRL, 2'b00}:
					s_nxt.rdata[0] = s_r.rai_los_dis;
				{`E3TX_IDX_STATUS, 2'b00}:
					s_nxt.rdata[3:0] = {s_r.pending, s_r.frames_left,
						s_r.frame_err};
				default: s_nxt.rresp = `E3TX_RESP_SLVERR;
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;
		// Pending request; a new edge wins over the take at frame start,
		// and many edges before one opportunity merge into one
		s_nxt.trig_prev = trig_level;
		if (take && s_r.pending)
		begin
			s_nxt.pending = 1'b0;
			s_nxt.frames_left = framing_error_type[1] ? `E3TX_BURST_LEFT
				: 2'h0;
			s_nxt.err_word = framing_error_type[0];
		end
		else if (take && (s_r.frames_left != 2'h0))
			s_nxt.frames_left = s_r.frames_left - 2'h1;
		if (take)
			s_nxt.frame_err = frame_err_now;
		if (trig_edge && framing_error_inject_enable)
			s_nxt.pending = 1'b1;
		if (!framing_error_inject_enable)
		begin
			s_nxt.pending = 1'b0;
			s_nxt.frames_left = 2'h0;
		end
		// Output stage; the alarm overrides everything, errors ride on
		// top of generated or passed-through overhead alike
		s_nxt.out_valid = in_valid;
		s_nxt.out_start = in_valid && (pos == 11'h000);
		if (in_valid)
		begin
			s_nxt.pos = (pos == `E3TX_FRAME_LAST) ? 11'h000 : pos + 11'h001;
			s_nxt.out_bit = force_all_ones_alarm | (gen_bit ^ apply);
		end
	end

	// Single registered state; everything clears on reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_r <= '0;
			s_r.ctrl <= `E3TX_CONTROL_RST;
			s_r.eins <= `E3TX_ERR_INS_RST;
		end
		else
			s_r <= s_nxt;
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign tx_bit_r = s_r.out_bit;
	assign tx_valid_r = s_r.out_valid;
	assign tx_frame_start_r = s_r.out_start;

	// Checks of the stream and the insertion sequencing
	sequence s_take_single;
		take && s_r.pending && !framing_error_type[1];
	endsequence
	sequence s_take_burst;
		take && s_r.pending && framing_error_type[1];
	endsequence

	a_ais_all_ones: assert property (@(posedge clk) disable iff (sys_rst)
		in_valid && force_all_ones_alarm |=> tx_bit_r && tx_valid_r)
		else $error("alarm did not force ones");
	a_n_const_one: assert property (@(posedge clk) disable iff (sys_rst)
		in_valid && !force_all_ones_alarm && !frame_generation_disable
		&& pos == `E3TX_N_POS && n_bit_source_select == e3tx_pkg::E3TX_N_ONE
		|=> tx_bit_r)
		else $error("N bit not one");
	a_a_forced_zero: assert property (@(posedge clk) disable iff (sys_rst)
		in_valid && !force_all_ones_alarm && !frame_generation_disable
		&& pos == `E3TX_A_POS && a_bit_source_select == e3tx_pkg::E3TX_A_ZERO
		|=> !tx_bit_r)
		else $error("A bit not zero");
	a_a_auto_los: assert property (@(posedge clk) disable iff (sys_rst)
		in_valid && !force_all_ones_alarm && !frame_generation_disable
		&& pos == `E3TX_A_POS && a_bit_source_select == e3tx_pkg::E3TX_A_AUTO
		|=> tx_bit_r == $past(rx_los & ~s_r.rai_los_dis))
		else $error("auto A bit wrong");
	a_pass_through: assert property (@(posedge clk) disable iff (sys_rst)
		in_valid && frame_generation_disable && !force_all_ones_alarm
		&& !apply |=> tx_bit_r == $past(in_bit))
		else $error("overhead not passed through");
	a_no_insert_off: assert property (@(posedge clk) disable iff (sys_rst)
		!framing_error_inject_enable |-> !apply ##1 !s_r.pending)
		else $error("error applied while disabled");
	a_edge_pends: assert property (@(posedge clk) disable iff (sys_rst)
		trig_edge && framing_error_inject_enable |=> s_r.pending)
		else $error("trigger edge lost");
	a_single_once: assert property (@(posedge clk) disable iff (sys_rst)
		s_take_single ##0 !trig_edge |=> s_r.frames_left == 2'h0 && !s_r.pending)
		else $error("single error repeated");
	a_burst_four: assert property (@(posedge clk) disable iff (sys_rst)
		s_take_burst ##0 framing_error_inject_enable
		|=> s_r.frames_left == `E3TX_BURST_LEFT && s_r.frame_err)
		else $error("burst not armed for four frames");
	a_fas_error: assert property (@(posedge clk) disable iff (sys_rst)
		apply && !force_all_ones_alarm |=> tx_bit_r == !$past(gen_bit))
		else $error("framing error not inverted");
	a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
		&& s_r.ctrl[15:10] == 6'h00 && s_r.eins[15:5] == 11'h000)
		else $error("reserved bits nonzero");
endmodule

/* e3tx_regs.svh */
// Register indices, field positions, reset values and frame constants
`ifndef E3TX_REGS_SVH
`define E3TX_REGS_SVH
`define E3TX_ADDR_W 16
`define E3TX_IDX_CONTROL 14'h0118
`define E3TX_IDX_ERR_INS 14'h011a
`define E3TX_IDX_RAI_CTRL 14'h0140
`define E3TX_IDX_STATUS 14'h0141
`define E3TX_CONTROL_RST 16'h0000
`define E3TX_ERR_INS_RST 16'h0000
`define E3TX_CONTROL_MASK 16'h030f
`define E3TX_ERR_INS_MASK 16'h001f
`define E3TX_N_SRC_LSB 8
`define E3TX_A_SRC_LSB 2
`define E3TX_FGD_BIT 1
`define E3TX_AIS_BIT 0
`define E3TX_ETYPE_LSB 3
`define E3TX_FEI_BIT 2
`define E3TX_SWERR_BIT 1
`define E3TX_TRIGSEL_BIT 0
`define E3TX_RAI_LOS_DIS_BIT 0
`define E3TX_FRAME_LAST 11'h5ff
`define E3TX_FAS_PATTERN 10'h3d0
`define E3TX_FAS_LEN 11'h00a
`define E3TX_A_POS 11'h00a
`define E3TX_N_POS 11'h00b
`define E3TX_BURST_LEFT 2'h3
`define E3TX_RESP_OKAY 2'h0
`define E3TX_RESP_SLVERR 2'h2
`endif

/* e3tx_pkg.sv */
// Types shared by the E3 transmit overhead and error insertion block
package e3tx_pkg;
	typedef enum logic [1:0] {
		E3TX_N_ONE = 2'b00,
		E3TX_N_HDLC = 2'b01,
		E3TX_N_FEAC = 2'b10,
		E3TX_N_ZERO = 2'b11
	} e3tx_nsrc_t;
	typedef enum logic [1:0] {
		E3TX_A_AUTO = 2'b00,
		E3TX_A_FEAC = 2'b01,
		E3TX_A_ZERO = 2'b10,
		E3TX_A_ONE = 2'b11
	} e3tx_asrc_t;
	typedef struct packed {
		logic awready, wready, bvalid, aw_got, w_got;
		logic [1:0] bresp;
		logic [15:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic arready, rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] ctrl, eins;
		logic rai_los_dis, trig_prev, pending, frame_err, err_word;
		logic [1:0] frames_left;
		logic [10:0] pos;
		logic out_bit, out_valid, out_start;
	} e3tx_state_t;
endpackage

/* e3tx_line_model.sv */
// Far-end line model: collects overhead bits of each frame
module e3tx_line_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_bit_r,
	input wire logic tx_valid_r,
	input wire logic tx_frame_start_r,
	output logic [15:0] frames_r,
	output logic [11:0] oh_r,
	output logic ones_r,
	output logic [11:0] len_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] cur, pos;
	logic all1, seen;
	// A frame is reported only once its end is seen; partial ones drop
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			frames_r <= 16'h0000;
			seen <= 1'b0;
			pos <= 12'h000;
		end
		else if (tx_valid_r && tx_frame_start_r)
		begin
			if (seen)
			begin
				frames_r <= frames_r + 16'h0001;
				oh_r <= cur;
				ones_r <= all1;
				len_r <= pos;
			end
			seen <= 1'b1;
			pos <= 12'h001;
			cur <= {11'h000, tx_bit_r};
			all1 <= tx_bit_r;
		end
		else if (tx_valid_r)
		begin
			if (pos < 12'h00c)
				cur[pos[3:0]] <= tx_bit_r;
			all1 <= all1 & tx_bit_r;
			pos <= pos + 12'h001;
		end
	end
endmodule

/* tb_e3tx_top.sv */
// Testbench: registers, overhead sources, alarm and error insertion
`include "e3tx_regs.svh"
module tb_e3tx_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] A_CTL = 16'(`E3TX_IDX_CONTROL) << 2;
	localparam logic [15:0] A_EIN = 16'(`E3TX_IDX_ERR_INS) << 2;
	localparam logic [15:0] A_RAI = 16'(`E3TX_IDX_RAI_CTRL) << 2;
	logic clk, sys_rst, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
	logic [15:0] awa, ara, frames;
	logic [31:0] wd, rdat, rd_v;
	logic [3:0] ws;
	logic [1:0] bresp, rresp, rd_resp, wr_resp;
	logic in_bit, in_v, in_s, hdlc, feac, los, man, inv;
	logic tx_b, tx_v, tx_s, ones;
	logic [11:0] oh, len, base;
	logic [10:0] pos;
	int n_fail, tests_run;
	e3tx_top e3tx_top_i (.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .in_bit(in_bit),
		.in_valid(in_v), .in_frame_start(in_s), .hdlc_bit(hdlc),
		.feac_bit(feac), .rx_los(los), .manual_error_input(man),
		.tx_bit_r(tx_b), .tx_valid_r(tx_v), .tx_frame_start_r(tx_s));
	e3tx_line_model e3tx_line_model_i (.clk(clk), .sys_rst(sys_rst),
		.tx_bit_r(tx_b), .tx_valid_r(tx_v), .tx_frame_start_r(tx_s),
		.frames_r(frames), .oh_r(oh), .ones_r(ones), .len_r(len));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Input stream; sources flip with inv so each selection differs
	always @(posedge clk)
	begin
		pos <= (sys_rst || pos == `E3TX_FRAME_LAST) ? 11'h000 : pos + 11'h001;
		in_v <= !sys_rst;
		in_s <= !sys_rst && pos == 11'h000;
		in_bit <= pos[0];
		feac <= pos[0] ^ inv;
		hdlc <= inv;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		$display("%0d comparisons, %0d mismatches", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task hang;
		n_fail++;
		$display("mismatch at %0t: wait timed out", $time);
		tally_and_finish;
	endtask
	// Ready is sampled between edges so the handshake edge is known;
	// bready and rready stay high once raised, so no call lowers and
	// raises them in one time step
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		tb = 1'b0;
		for (int i = 0; i < 64 && !tb; i++)
		begin
			@(negedge clk);
			ta = awv & awr;
			tw = wv & wr_r;
			tb = bv & br;
			wr_resp = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		if (!tb) hang;
	endtask
	task automatic rd(input logic [15:0] a);
		logic ta, tr;
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		tr = 1'b0;
		for (int i = 0; i < 64 && !tr; i++)
		begin
			@(negedge clk);
			ta = arv & arr;
			tr = rv & rr;
			rd_v = rdat;
			rd_resp = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end
		if (!tr) hang;
	endtask
	// Waits for the next finished frame, then compares its overhead
	task automatic frm(input logic [11:0] e, input bit c);
		logic [15:0] f;
		f = frames;
		for (int i = 0; i < 2000 && frames === f; i++)
			@(posedge clk);
		if (frames === f) hang;
		if (c) chk(32'(oh), 32'(e));
	endtask
	function automatic logic [11:0] exp_oh(input logic a, input logic n);
		logic [9:0] fas;
		logic [11:0] e;
		fas = `E3TX_FAS_PATTERN;
		for (int i = 0; i < 10; i++)
			e[i] = fas[9 - i];
		e[10] = a;
		e[11] = n;
		return e;
	endfunction
	initial
	begin
		logic [3:0] nx, ax;
		int a, t;
		sys_rst = 1'b1;
		{awv, wv, br, arv, rr, in_bit, in_v, in_s} = 8'h00;
		{hdlc, feac, los, man, inv} = 5'h00;
		{awa, ara, wd, ws, pos} = '0;
		n_fail = 0;
		tests_run = 0;
		base = exp_oh(1'b0, 1'b1);
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		ws <= 4'hf;
		rd(A_CTL);
		chk(rd_v, 32'(`E3TX_CONTROL_RST));
		rd(A_EIN);
		chk(rd_v, 32'(`E3TX_ERR_INS_RST));
		wr(A_CTL, 32'hffffffff);
		chk(32'(wr_resp), 32'(`E3TX_RESP_OKAY));
		rd(A_CTL);
		chk(rd_v, 32'(`E3TX_CONTROL_MASK));
		wr(A_EIN, 32'h0000ffe0);
		rd(A_EIN);
		chk(rd_v, 32'h00000000);
		rd(16'h0470);
		chk(32'(rd_resp), 32'(`E3TX_RESP_SLVERR));
		wr(16'h0470, 32'h0000ffff);
		chk(32'(wr_resp), 32'(`E3TX_RESP_SLVERR));
		rd(A_CTL);
		chk(rd_v, 32'(`E3TX_CONTROL_MASK));
		$display("test registers done");
		// Every N and A source, both polarities; k=2 gives the FEAC pair
		for (int v = 0; v < 2; v++)
			for (int k = 0; k < 4; k++)
			begin
				inv <= v[0];
				los <= v[0];
				a = (k + 3) % 4;
				nx = {1'b0, ~v[0], v[0], 1'b1};
				ax = {1'b1, 1'b0, v[0], v[0]};
				wr(A_CTL, (32'(k) << 8) | (32'(a) << 2));
				frm(0, 0);
				frm(exp_oh(ax[a], nx[k]), 1);
			end
		wr(A_CTL, 0);
		wr(A_RAI, 1);
		frm(0, 0);
		frm(base, 1);
		wr(A_RAI, 0);
		los <= 1'b0;
		inv <= 1'b0;
		$display("test sources done");
		wr(A_CTL, 32'h2);
		frm(0, 0);
		frm(12'haaa, 1);
		wr(A_CTL, 32'h3);
		frm(0, 0);
		frm(12'hfff, 1);
		chk(32'(ones), 32'h1);
		chk(32'(len), 32'h00000600);
		wr(A_CTL, 0);
		$display("test alarm done");
		// Each type, triggered by a doubled software edge
		for (t = 0; t < 4; t++)
		begin
			frm(0, 0);
			wr(A_EIN, (32'(t) << 3) | 32'h4);
			wr(A_EIN, (32'(t) << 3) | 32'h6);
			wr(A_EIN, (32'(t) << 3) | 32'h4);
			wr(A_EIN, (32'(t) << 3) | 32'h6);
			frm(0, 0);
			for (int f = 0; f < (t > 1 ? 5 : 2); f++)
				frm(base ^ ((f < (t > 1 ? 4 : 1)) ?
					(t[0] ? 12'h3ff : 12'h001) : 12'h000), 1);
		end
		wr(A_EIN, 0);
		wr(A_EIN, 32'h2);
		frm(base, 1);
		frm(base, 1);
		$display("test software insertion done");
		// Manual strobe selected; software edge must be ignored. Frame
		// generation is off here, so the error rides on passed overhead
		wr(A_EIN, 0);
		wr(A_EIN, 32'h0d);
		wr(A_CTL, 32'h2);
		frm(0, 0);
		wr(A_EIN, 32'h0f);
		frm(0, 0);
		frm(12'haaa, 1);
		man <= 1'b1;
		repeat (4) @(posedge clk);
		man <= 1'b0;
		frm(0, 0);
		frm(12'h955, 1);
		frm(12'haaa, 1);
		wr(A_EIN, 32'h0d);
		wr(A_EIN, 0);
		wr(A_CTL, 0);
		$display("test manual insertion done");
		tally_and_finish;
	end
endmodule
